// File: hdl/thp_dev.sv
`timescale 1ns/10ps
module thp_dev (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  thp_if.dev               bus,
  input  wire logic [15:0] stream_active,
  output logic      [15:0] stream_oe,
  output logic      [7:0]  ext_hiz_ctrl,
  output logic             output_standby_bit
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [35:0] pin_async;
  logic [35:0] pin_sync;
  logic        s_cs_n;
  logic        s_strobe;
  logic        s_dir;
  logic        s_style;
  logic        s_ode_n;
  logic        s_rst_n;

  // Pull-ups: style and ode default high when floating
  assign pin_async = {bus.cs_n, bus.strobe_or_read, bus.dir_or_write_strobe,
                      bus.bus_style_select, ~bus.output_drive_enable_pin,
                      bus.rst_n, bus.addr, bus.data_from_host};

  thp_sync #(.W(36)) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (pin_async),
    .sync_out (pin_sync)
  );

  assign s_cs_n   = pin_sync[35];
  assign s_strobe = pin_sync[34];
  assign s_dir    = pin_sync[33];
  assign s_style  = pin_sync[32];
  assign s_ode_n  = pin_sync[31];
  assign s_rst_n  = pin_sync[30];

  // Address and data share the sync; host sets them a cycle before the strobe
  logic [13:0] addr_q;
  logic [15:0] wdata_q;
  assign addr_q  = pin_sync[29:16];
  assign wdata_q = pin_sync[15:0];

  // ---------------------------------------------------------------
  // Reset and access decode
  // ---------------------------------------------------------------
  logic dev_rst;
  logic sel;
  logic rd_req;
  logic wr_req;
  logic req;
  logic is_ctrl;
  logic is_mem;
  logic [3:0] mem_idx;

  assign dev_rst = ~s_rst_n;
  assign sel     = ~s_cs_n;
  // Data-strobe: strobe low with select, level gives direction
  // Separate: each strobe low names its own access
  assign rd_req  = sel & (s_style ? (~s_strobe & s_dir)
                                  : ~s_strobe);
  assign wr_req  = sel & (s_style ? (~s_strobe & ~s_dir)
                                  : (~s_dir & s_strobe));
  assign req     = rd_req | wr_req;
  assign is_ctrl = (addr_q == 14'(thp_pkg::CTRL_ADDR));
  assign is_mem  = (addr_q[13:thp_pkg::MEM_IDX_W] == 10'h001);
  assign mem_idx = addr_q[thp_pkg::MEM_IDX_W-1:0];

  // ---------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } thp_state_t;

  thp_state_t state;
  thp_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       do_write;
  logic       done;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      ST_IDLE: begin
        next_cnt = 4'h0;
        if (req) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_cnt = cnt + 4'h1;
        if (!req) begin
          next_state = ST_IDLE;
        end else if (cnt == 4'(thp_pkg::ACK_CYC - 1)) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // Holds until the strobe is withdrawn; one access per strobe
        if (!req) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign do_write = (state == ST_WAIT) && (next_state == ST_DONE) && wr_req;
  assign done     = (state == ST_DONE);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end else if (dev_rst) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Control word and small memory
  // ---------------------------------------------------------------
  logic [15:0] ctrl;
  logic [15:0] mem [thp_pkg::MEM_DEPTH];
  logic [15:0] rd_mux;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= thp_pkg::CTRL_RESET;
    end else if (dev_rst) begin
      ctrl <= thp_pkg::CTRL_RESET;
    end else if (do_write && is_ctrl) begin
      ctrl <= wdata_q;
    end
  end

  for (genvar i = 0; i < thp_pkg::MEM_DEPTH; i++) begin : g_mem
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem[i] <= thp_pkg::MEM_RESET;
      end else if (dev_rst) begin
        mem[i] <= thp_pkg::MEM_RESET;
      end else if (do_write && is_mem && (mem_idx == 4'(i))) begin
        mem[i] <= wdata_q;
      end
    end
  end

  // Unmapped addresses read zero
  assign rd_mux = is_ctrl ? ctrl : (is_mem ? mem[mem_idx] : 16'h0000);
  assign output_standby_bit = ctrl[thp_pkg::STBY_BIT];

  // ---------------------------------------------------------------
  // Host bus drive
  // ---------------------------------------------------------------
  logic [15:0] rdata;
  logic        rd_oe;
  logic        ack;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 16'h0000;
      rd_oe <= 1'b0;
      ack   <= 1'b0;
    end else begin
      rdata <= (next_state == ST_DONE) ? rd_mux : rdata;
      rd_oe <= rd_req & ~dev_rst;
      // Data-strobe style: low means done; separate style: rising edge
      ack   <= s_style ? ~(next_state == ST_DONE)
                       : (next_state == ST_DONE);
    end
  end

  // Released while deselected; external pull keeps the idle level
  assign bus.data_from_dev    = rdata;
  assign bus.data_from_dev_oe = rd_oe & sel;
  assign bus.transfer_ack     = ack;
  assign bus.transfer_ack_oe  = sel & ~dev_rst;

  // ---------------------------------------------------------------
  // Stream and hiz control
  // ---------------------------------------------------------------
  logic out_en;
  logic hiz_en;

  assign out_en = ~s_ode_n & ~dev_rst;
  assign hiz_en = out_en & output_standby_bit;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stream_oe    <= 16'h0000;
      ext_hiz_ctrl <= 8'hff;
    end else begin
      // Standby bit gates the streams as well as the hiz controls
      stream_oe    <= hiz_en ? stream_active : 16'h0000;
      // Only streams 0-7 have a companion; high = channel idle
      ext_hiz_ctrl <= hiz_en ? ~stream_active[7:0] : 8'hff;
    end
  end
endmodule

// File: hdl/thp_pkg.sv
package thp_pkg;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned ADDR_W       = 14;
  localparam int unsigned NUM_STREAMS  = 16;
  localparam int unsigned NUM_HIZ      = 8;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned RST_MIN_NS   = 1000;
  localparam int unsigned RST_CYC      = (RST_MIN_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int unsigned WAKE_US      = 600;
  localparam int unsigned WAKE_CYC     = WAKE_US * CLK_MHZ;
  localparam int unsigned MEM_DEPTH    = 16;
  localparam int unsigned MEM_IDX_W    = 4;
  localparam int unsigned ACK_CYC      = 2;
  localparam int unsigned CTRL_ADDR    = 14'h0000;
  localparam int unsigned STBY_BIT     = 2;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] MEM_RESET    = 16'h0000;
  localparam int unsigned TIMER_W      = 20;
  localparam int unsigned CNT_W        = 4;
endpackage

// File: hdl/thp_if.sv
`timescale 1ns/10ps
interface thp_if;
  logic [13:0] addr;
  logic [15:0] data_from_host;
  logic        data_from_host_oe;
  logic [15:0] data_from_dev;
  logic        data_from_dev_oe;
  logic        cs_n;
  logic        strobe_or_read;
  logic        dir_or_write_strobe;
  logic        bus_style_select;
  logic        transfer_ack;
  logic        transfer_ack_oe;
  logic        rst_n;
  logic        output_drive_enable_pin;

  modport dev (
    input  addr,
    input  data_from_host,
    input  cs_n,
    input  strobe_or_read,
    input  dir_or_write_strobe,
    input  bus_style_select,
    input  rst_n,
    input  output_drive_enable_pin,
    output data_from_dev,
    output data_from_dev_oe,
    output transfer_ack,
    output transfer_ack_oe
  );

  modport host (
    output addr,
    output data_from_host,
    output data_from_host_oe,
    output cs_n,
    output strobe_or_read,
    output dir_or_write_strobe,
    output bus_style_select,
    output rst_n,
    output output_drive_enable_pin,
    input  data_from_dev,
    input  data_from_dev_oe,
    input  transfer_ack,
    input  transfer_ack_oe
  );
endinterface

// File: hdl/thp_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser, one per bit
module thp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        meta[i]     <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta[i]     <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end
endmodule

// File: hdl/thp_host.sv
`timescale 1ns/10ps
// Host end: drives the port, one access per command
module thp_host (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  thp_if.host              bus,
  input  wire logic        style_ds,
  input  wire logic        drive_en,
  input  wire logic        dev_reset_req,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [13:0] cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic      [15:0] rsp_rdata
);
  // ---------------------------------------------------------------
  // Device reset pulse and wake-up wait
  // ---------------------------------------------------------------
  logic [19:0] timer;
  logic        rst_phase;
  logic [1:0]  ack_sync;
  logic        ack_s;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Power-up low phase needs only the minimum width
      timer     <= 20'(thp_pkg::RST_CYC);
      rst_phase <= 1'b1;
    end else if (dev_reset_req) begin
      timer     <= 20'(thp_pkg::RST_CYC);
      rst_phase <= 1'b1;
    end else if (timer != 20'h00000) begin
      timer <= timer - 20'h00001;
    end else if (rst_phase) begin
      // Low phase over, now the stabilise wait
      timer     <= 20'(thp_pkg::WAKE_CYC);
      rst_phase <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_sync <= 2'b00;
    end else begin
      ack_sync <= {ack_sync[0], bus.transfer_ack};
    end
  end
  assign ack_s = ack_sync[1];

  // ---------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SETUP = 2'b01,
    HS_STRB = 2'b10,
    HS_END = 2'b11
  } thp_hstate_t;

  thp_hstate_t hs;
  logic        wr;
  logic [13:0] addr;
  logic [15:0] wdata;
  logic        ack_done;
  logic        ready_now;

  // Data-strobe style acks low; separate style acks high
  assign ack_done  = style_ds ? ~ack_s : ack_s;
  assign ready_now = (hs == HS_IDLE) && !rst_phase && (timer == 20'h00000);
  assign cmd_ready = ready_now;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs        <= HS_IDLE;
      wr        <= 1'b0;
      addr      <= 14'h0000;
      wdata     <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      unique case (hs)
        HS_IDLE: begin
          if (cmd_valid && ready_now) begin
            hs    <= HS_SETUP;
            wr    <= cmd_write;
            addr  <= cmd_addr;
            wdata <= cmd_wdata;
          end
        end
        HS_SETUP: hs <= HS_STRB;
        HS_STRB: begin
          if (ack_done) begin
            hs        <= HS_END;
            rsp_valid <= ~wr;
            rsp_rdata <= bus.data_from_dev;
          end
        end
        HS_END: begin
          if (!ack_done) begin
            hs <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic strobe_on;
  assign strobe_on = (hs == HS_STRB);

  assign bus.rst_n                   = ~rst_phase | (timer == 20'h00000);
  assign bus.bus_style_select        = style_ds;
  assign bus.output_drive_enable_pin = drive_en;
  assign bus.addr                    = addr;
  assign bus.cs_n                    = ~(strobe_on | (hs == HS_SETUP));
  assign bus.data_from_host          = wdata;
  assign bus.data_from_host_oe       = wr & (hs != HS_IDLE);
  assign bus.strobe_or_read          = style_ds ? ~strobe_on
                                                : ~(strobe_on & ~wr);
  assign bus.dir_or_write_strobe     = style_ds ? ~wr
                                                : ~(strobe_on & wr);
endmodule

// File: dv/thp_sva.sv
`timescale 1ns/10ps
module thp_sva (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        cs_n,
  input wire logic        strobe_or_read,
  input wire logic        dir_or_write_strobe,
  input wire logic        bus_style_select,
  input wire logic        transfer_ack,
  input wire logic        transfer_ack_oe,
  input wire logic        data_from_dev_oe,
  input wire logic        data_from_host_oe,
  input wire logic        rst_n,
  input wire logic        output_drive_enable_pin,
  input wire logic [7:0]  ext_hiz_ctrl,
  input wire logic [15:0] stream_oe,
  input wire logic        output_standby_bit
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Runs of four cover the two-flop input sync plus the output register
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_ode_hiz;
    !output_drive_enable_pin [*4] |-> ext_hiz_ctrl == 8'hff;
  endproperty
  a_ode_hiz: assert property (p_ode_hiz)
    else $error("hiz outputs not high with drive enable low");
  property p_ode_str;
    !output_drive_enable_pin [*4] |-> stream_oe == 16'h0000;
  endproperty
  a_ode_str: assert property (p_ode_str)
    else $error("streams driven with drive enable low");
  property p_stby;
    !output_standby_bit [*3] |-> ext_hiz_ctrl == 8'hff && stream_oe == 16'h0000;
  endproperty
  a_stby: assert property (p_stby)
    else $error("outputs active with standby bit low");
  property p_rst_out;
    !rst_n [*4] |-> ext_hiz_ctrl == 8'hff && stream_oe == 16'h0000 && !transfer_ack_oe;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs active in device reset");
  property p_rst_clr;
    !rst_n [*4] |-> !output_standby_bit;
  endproperty
  a_rst_clr: assert property (p_rst_clr)
    else $error("control bit kept through device reset");
  property p_desel;
    cs_n [*3] |-> !data_from_dev_oe && !transfer_ack_oe;
  endproperty
  a_desel: assert property (p_desel)
    else $error("port driven while deselected");
  property p_oe_excl;
    // Select reaches the port through two flops
    data_from_dev_oe |-> !$past(cs_n, 2) && !data_from_host_oe;
  endproperty
  a_oe_excl: assert property (p_oe_excl)
    else $error("data bus driven outside a read");
  property p_ds_cause;
    bus_style_select && transfer_ack_oe && !transfer_ack |->
      !$past(strobe_or_read, 1) || !$past(strobe_or_read, 2) || !$past(strobe_or_read, 3);
  endproperty
  a_ds_cause: assert property (p_ds_cause)
    else $error("ack low without a strobe");
  property p_ds_time;
    bus_style_select && !cs_n && $fell(strobe_or_read) |->
      ##[1:12] (transfer_ack_oe && !transfer_ack);
  endproperty
  a_ds_time: assert property (p_ds_time)
    else $error("no ack low after data strobe");
  property p_sep_time;
    !bus_style_select && !cs_n && ($fell(strobe_or_read) || $fell(dir_or_write_strobe)) |->
      ##[1:12] (transfer_ack_oe && $rose(transfer_ack));
  endproperty
  a_sep_time: assert property (p_sep_time)
    else $error("no ack rise after strobe");
  c_ds_ack: cover property (bus_style_select && transfer_ack_oe && !transfer_ack);
  c_sep_ack: cover property (!bus_style_select && transfer_ack_oe && $rose(transfer_ack));
  c_stby: cover property ($rose(output_standby_bit));
endmodule

// File: dv/tb_tdm_switch_host_port_ctrl.sv
`timescale 1ns/10ps
module tb_tdm_switch_host_port_ctrl;
  // One wake wait dominates the run; ceiling leaves some margin
  localparam int CEIL = 80000;
  logic        sys_clk;
  logic        sys_rst;
  logic        style_ds;
  logic        drive_en;
  logic        dev_reset_req;
  logic        cmd_valid;
  logic        cmd_write;
  logic [13:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic [15:0] stream_active;
  logic [15:0] stream_oe;
  logic [7:0]  ext_hiz_ctrl;
  logic        output_standby_bit;
  logic        ack_wire;
  logic [15:0] rd;
  int          err_count;
  int          samples_checked;
  int          cyc;
  // ----------------------------------------
  // Both ends and checker
  // ----------------------------------------
  thp_if thp_if_inst ();
  thp_dev thp_dev_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(thp_if_inst),
    .stream_active(stream_active), .stream_oe(stream_oe), .ext_hiz_ctrl(ext_hiz_ctrl),
    .output_standby_bit(output_standby_bit));
  thp_host thp_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(thp_if_inst),
    .style_ds(style_ds), .drive_en(drive_en), .dev_reset_req(dev_reset_req),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  // Board resistor: pull-up in data-strobe style, pull-down otherwise
  assign ack_wire = thp_if_inst.transfer_ack_oe ? thp_if_inst.transfer_ack
                                                : thp_if_inst.bus_style_select;
  thp_sva thp_sva_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(thp_if_inst.cs_n),
    .strobe_or_read(thp_if_inst.strobe_or_read),
    .dir_or_write_strobe(thp_if_inst.dir_or_write_strobe),
    .bus_style_select(thp_if_inst.bus_style_select),
    .transfer_ack(thp_if_inst.transfer_ack), .transfer_ack_oe(thp_if_inst.transfer_ack_oe),
    .data_from_dev_oe(thp_if_inst.data_from_dev_oe),
    .data_from_host_oe(thp_if_inst.data_from_host_oe), .rst_n(thp_if_inst.rst_n),
    .output_drive_enable_pin(thp_if_inst.output_drive_enable_pin),
    .ext_hiz_ctrl(ext_hiz_ctrl), .stream_oe(stream_oe),
    .output_standby_bit(output_standby_bit));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      err_count++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic access(input logic wr, input logic [13:0] a, input logic [15:0] wd);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = wd;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (!wr && rsp_valid !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (!wr) chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    rd = rsp_rdata;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic outs(input logic [15:0] hiz, input logic [15:0] oe);
    repeat (8) @(negedge sys_clk);
    chk("ext_hiz_ctrl", hiz, {8'h00, ext_hiz_ctrl});
    chk("stream_oe", oe, stream_oe);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    int n;
    repeat (20) @(negedge sys_clk);
    chk("hiz in reset", 16'h00ff, {8'h00, ext_hiz_ctrl});
    chk("oe in reset", 16'h0000, stream_oe);
    chk("ack oe idle", 16'h0000, {15'h0000, thp_if_inst.transfer_ack_oe});
    n = 20;
    while (thp_if_inst.rst_n !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    chk("reset low time", 16'h0001, {15'h0000, n > thp_pkg::RST_MIN_NS / 10});
    n = 0;
    while (cmd_ready !== 1'b1 && n < 70000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("ready after wake", 16'h0001, {15'h0000, cmd_ready});
    chk("wake wait", 16'h0001, {15'h0000, n >= thp_pkg::WAKE_CYC});
    $display("test reset done");
  endtask
  task automatic t_ctrl;
    access(1'b0, 14'h0000, 16'h0000);
    chk("ctrl default", thp_pkg::CTRL_RESET, rd);
    drive_en = 1'b1;
    stream_active = 16'h3c5a;
    outs(16'h00ff, 16'h0000);
    access(1'b1, 14'h0000, 16'h0004);
    access(1'b0, 14'h0000, 16'h0000);
    chk("ctrl readback", 16'h0004, rd);
    outs(16'h00a5, 16'h3c5a);
    drive_en = 1'b0;
    outs(16'h00ff, 16'h0000);
    drive_en = 1'b1;
    outs(16'h00a5, 16'h3c5a);
    $display("test outputs done");
  endtask
  task automatic t_mem(input logic ds);
    logic [15:0] pat;
    @(negedge sys_clk);
    style_ds = ds;
    repeat (6) @(negedge sys_clk);
    chk("ack idle level", {15'h0000, ds}, {15'h0000, ack_wire});
    pat = ds ? 16'hc3a5 : 16'h5a3c;
    access(1'b1, 14'h0010, pat);
    access(1'b1, 14'h001f, ~pat);
    access(1'b1, 14'h0020, pat);
    access(1'b0, 14'h0010, 16'h0000);
    chk("mem low word", pat, rd);
    access(1'b0, 14'h001f, 16'h0000);
    chk("mem high word", ~pat, rd);
    access(1'b0, 14'h0020, 16'h0000);
    chk("unmapped word", 16'h0000, rd);
    chk("ack released", {15'h0000, ds}, {15'h0000, ack_wire});
    $display("test memory style %0d done", ds);
  endtask
  task automatic t_devrst;
    @(negedge sys_clk);
    dev_reset_req = 1'b1;
    @(negedge sys_clk);
    dev_reset_req = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("standby after reset", 16'h0000, {15'h0000, output_standby_bit});
    chk("hiz in mid reset", 16'h00ff, {8'h00, ext_hiz_ctrl});
    chk("oe in mid reset", 16'h0000, stream_oe);
    chk("ready in mid reset", 16'h0000, {15'h0000, cmd_ready});
    $display("test device reset done");
  endtask
  initial begin
    sys_rst = 1'b1;
    style_ds = 1'b1;
    drive_en = 1'b0;
    dev_reset_req = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 14'h0000;
    cmd_wdata = 16'h0000;
    stream_active = 16'h0000;
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_ctrl();
    t_mem(1'b1);
    t_mem(1'b0);
    t_devrst();
    end_of_test();
  end
endmodule
